// ==== src/gate_defines.vh ====
// Constants for the swing gate mode controller
// Function
// [RULE1] Power-up lights all indicators with two-tone sound, then only red stop after 3 s
// [RULE2] Panel away from home at power-up is homed, then always-locked
// [RULE3] Start in always-locked after power-up when mechanical release lock engaged
// [RULE4] Stop selects always-locked and drives panel home
// [RULE5] Single passage releases lock and rotates panel toward permitted direction
// [RULE6] Single passage holds passage open for programmable wait, default 5 s
// [RULE7] Infinite wait holds passage open until a stop command
// [RULE8] Wait expiry drives panel home and selects always-locked
// [RULE9] Wait count starts only once panel passes 83 degrees
// [RULE10] Always-free runs no timer, stays open until stop, then locks
// [RULE11] Pulse: stop locks, direction single passage, stop plus direction always-free
// [RULE12] Most recently received command from panel or connector wins
// [RULE13] Same-direction new mode before home executes at once without homing
// [RULE14] Opposite-direction mode before home is buffered, run after homing
// [RULE15] Always-free during single passage keeps current open position
// [RULE16] Level control: passage open while direction input held, lock on release
// [RULE17] Level control: held panel stop locks despite held direction input
// [RULE18] Level control ignores connector stop input
// [RULE19] Level control: held panel direction button opens until release
// [RULE20] Open fire loop releases lock, removes drive, ignores all commands; an open loop during power-up keeps the lock engaged
// [RULE21] Closing fire loop repeats power-up and enters always-locked
// [RULE22] Forced over 10 s: overload, blink all, 3 beeps per 20 s, until home
// [RULE23] All inputs synchronised and debounced; one press gives one command; the code conditions only the buttons, connector inputs and fire loop
`ifndef GATE_DEFINES_VH
`define GATE_DEFINES_VH
`define CLK_HZ         200000000
`define STARTUP_MS     3000
`define WAIT_DEF_S     5
`define FORCE_MS       10000
`define BEEP_PERIOD_MS 20000
`define BEEP_MS        150
`define BLINK_MS       500
`define TONE_MS        1500
`define DEBOUNCE_MS    20
`define WAIT_W         8
`define WAIT_INFINITE  8'hff
`define MODE_LOCKED    2'h0
`define MODE_SINGLE    2'h1
`define MODE_FREE      2'h2
`endif

// ==== src/input_conditioner.v ====
// Synchroniser and debouncer for one input line
`timescale 1ns/1ps
`default_nettype none
module input_conditioner #(
  parameter integer STABLE_CYC = 4000000
) (
  input  wire ref_clk,
  input  wire rst_n,
  input  wire raw_in,
  output reg  level_out,
  output reg  rise_out
);
  reg        s1_r;
  reg        s2_r;
  reg [22:0] cnt_r;

  // Two-stage sync; only the second stage feeds the filter
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r      <= 1'b0;
      s2_r      <= 1'b0;
      cnt_r     <= 23'h0;
      level_out <= 1'b0;
      rise_out  <= 1'b0;
    end
    else
    begin
      s1_r     <= raw_in;
      s2_r     <= s1_r;
      rise_out <= 1'b0;
      if (s2_r == level_out)
        cnt_r <= 23'h0;
      else if (cnt_r >= STABLE_CYC[22:0] - 23'h1)
      begin
        cnt_r     <= 23'h0;
        level_out <= s2_r;
        rise_out  <= s2_r; // One pulse per accepted press [RULE23]
      end
      else
        cnt_r <= cnt_r + 23'h1;
    end
  end
endmodule // input_conditioner
`default_nettype wire

// ==== src/ms_timer.v ====
// Free-running millisecond tick generator
`timescale 1ns/1ps
`default_nettype none
module ms_timer #(
  parameter integer CYC_PER_MS = 200000
) (
  input  wire ref_clk,
  input  wire rst_n,
  output reg  ms_tick
);
  reg [17:0] cnt_r;

  // Divide the clock down so long timers stay narrow
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r   <= 18'h0;
      ms_tick <= 1'b0;
    end
    else if (cnt_r >= CYC_PER_MS[17:0] - 18'h1)
    begin
      cnt_r   <= 18'h0;
      ms_tick <= 1'b1;
    end
    else
    begin
      cnt_r   <= cnt_r + 18'h1;
      ms_tick <= 1'b0;
    end
  end
endmodule // ms_timer
`default_nettype wire

// ==== src/swing_gate_mode_control.v ====
// Mode-control state machine of the swing gate controller
`timescale 1ns/1ps
`default_nettype none
`include "gate_defines.vh"
module swing_gate_mode_control #(
  parameter integer CYC_PER_MS   = `CLK_HZ / 1000,
  parameter integer DEBOUNCE_CYC = (`CLK_HZ / 1000) * `DEBOUNCE_MS
) (
  input  wire       ref_clk,
  input  wire       rstn,
  input  wire       panel_stop_btn,
  input  wire       panel_left_btn,
  input  wire       panel_right_btn,
  input  wire       access_control_stop,
  input  wire       access_control_left,
  input  wire       access_control_right,
  input  wire       fire_alarm_loop_closed,
  input  wire       level_control,
  input  wire [7:0] wait_time_s,
  input  wire       release_lock_engaged,
  input  wire       panel_at_home,
  input  wire       panel_past_83,
  input  wire       panel_forced,
  output reg        lock_release,
  output reg        drive_enable,
  output reg        drive_open_left,
  output reg        drive_open_right,
  output reg        drive_home,
  output reg        led_stop_red,
  output reg        led_left_green,
  output reg        led_right_green,
  output reg        buzzer_on,
  output reg        buzzer_two_tone,
  output reg  [1:0] mode_out,
  output reg        overload_out
);
  // One-hot states
  localparam [5:0] S_STARTUP  = 6'h01;
  localparam [5:0] S_HOMING   = 6'h02;
  localparam [5:0] S_LOCKED   = 6'h04;
  localparam [5:0] S_OPEN     = 6'h08;
  localparam [5:0] S_FIRE     = 6'h10;
  localparam [5:0] S_OVERLOAD = 6'h20;

  // Reset release through two flops
  reg rst_a_r;
  reg rst_n_r;
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_a_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_a_r <= 1'b1;
      rst_n_r <= rst_a_r;
    end
  end

  // Conditioned inputs; fire loop is included so bounces cannot trip it
  wire [6:0] raw_in = {fire_alarm_loop_closed, access_control_right,
                       access_control_left, access_control_stop,
                       panel_right_btn, panel_left_btn, panel_stop_btn};
  wire [6:0] lvl;
  wire [6:0] rise;
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1)
    begin : g_cond
      input_conditioner #(.STABLE_CYC(DEBOUNCE_CYC)) u_cond (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n_r),
        .raw_in    (raw_in[gi]),
        .level_out (lvl[gi]),
        .rise_out  (rise[gi])
      ); // [RULE23]
    end
  endgenerate

  wire ms_tick;
  ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_ms (
    .ref_clk (ref_clk),
    .rst_n   (rst_n_r),
    .ms_tick (ms_tick)
  );

  // Decode a pulse command from a stop/left/right group
  // Result: {valid, dir_right, mode[1:0]}
  function [3:0] decode_cmd;
    input s_lv, l_lv, r_lv, any_rise;
    begin
      decode_cmd = 4'h0;
      if (any_rise)
      begin
        if (s_lv && (l_lv || r_lv))
          decode_cmd = {1'b1, r_lv, `MODE_FREE}; // [RULE11]
        else if (l_lv || r_lv)
          decode_cmd = {1'b1, r_lv, `MODE_SINGLE}; // [RULE11]
        else if (s_lv)
          decode_cmd = {1'b1, 1'b0, `MODE_LOCKED}; // [RULE11]
      end
    end
  endfunction

  wire [3:0] pnl_cmd = decode_cmd(lvl[0], lvl[1], lvl[2], |rise[2:0]);
  wire [3:0] con_cmd = decode_cmd(lvl[3], lvl[4], lvl[5], |rise[5:3]);
  // Both sources in one cycle is rare; the connector is taken as later
  wire [3:0] cmd = con_cmd[3] ? con_cmd : pnl_cmd; // [RULE12]
  wire fire_ok = lvl[6];

  // Level-control request: connector or panel direction held, panel stop overrides
  wire lvl_l = (lvl[4] | lvl[1]) & ~lvl[0]; // [RULE16] [RULE17] [RULE19]
  wire lvl_r = (lvl[5] | lvl[2]) & ~lvl[0] & ~lvl_l; // [RULE18]

  reg  [5:0]  state_r;
  reg  [1:0]  mode_r;
  reg         dir_r;        // 1 = right
  reg         buf_v_r;
  reg  [2:0]  buf_r;        // {dir, mode}
  reg  [15:0] ms_r;
  reg  [7:0]  sec_r;
  reg  [15:0] force_ms_r;
  reg         counting_r;
  reg         hold_pos_r;

  // Main sequencer
  always @(posedge ref_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      state_r    <= S_STARTUP;
      mode_r     <= `MODE_LOCKED;
      dir_r      <= 1'b0;
      buf_v_r    <= 1'b0;
      buf_r      <= 3'h0;
      ms_r       <= 16'h0;
      sec_r      <= 8'h0;
      force_ms_r <= 16'h0;
      counting_r <= 1'b0;
      hold_pos_r <= 1'b0;
    end
    else if (!fire_ok && state_r != S_STARTUP)
    begin
      state_r <= S_FIRE; // Everything else ignored [RULE20]
      mode_r  <= `MODE_LOCKED;
      buf_v_r <= 1'b0;
    end
    else
    begin
      if (ms_tick)
        ms_r <= ms_r + 16'h1;
      case (state_r)
        S_STARTUP:
          if (fire_ok && ms_r >= `STARTUP_MS)
          begin
            mode_r  <= `MODE_LOCKED; // [RULE3]
            state_r <= panel_at_home ? S_LOCKED : S_HOMING; // [RULE1] [RULE2]
          end
        S_FIRE:
          if (fire_ok)
          begin
            state_r <= S_STARTUP; // [RULE21]
            ms_r    <= 16'h0;
          end
        S_OVERLOAD:
          if (panel_at_home)
          begin
            state_r <= S_LOCKED;
            mode_r  <= `MODE_LOCKED;
          end
          else if (ms_r >= `BEEP_PERIOD_MS - 1 && ms_tick)
            ms_r <= 16'h0;
        S_HOMING:
          if (level_control && (lvl_l || lvl_r))
          begin
            dir_r   <= lvl_r;
            hold_pos_r <= 1'b0;
            mode_r  <= `MODE_SINGLE;
            state_r <= S_OPEN;
          end
          else if (!level_control && cmd[3] && cmd[1:0] != `MODE_LOCKED
                   && cmd[2] == dir_r)
          begin
            mode_r     <= cmd[1:0]; // [RULE13]
            state_r    <= S_OPEN;
            hold_pos_r <= 1'b0;
            counting_r <= 1'b0;
          end
          else if (!level_control && cmd[3] && cmd[1:0] != `MODE_LOCKED)
          begin
            buf_v_r <= 1'b1; // [RULE14]
            buf_r   <= cmd[2:0];
          end
          else if (!level_control && cmd[3])
            buf_v_r <= 1'b0;
          else if (panel_at_home)
          begin
            if (buf_v_r)
            begin
              buf_v_r <= 1'b0;
              dir_r   <= buf_r[2];
              mode_r  <= buf_r[1:0]; // [RULE14]
              state_r <= S_OPEN;
              hold_pos_r <= 1'b0;
            end
            else
            begin
              mode_r  <= `MODE_LOCKED;
              state_r <= S_LOCKED;
            end
          end
        S_LOCKED:
          if (level_control && (lvl_l || lvl_r))
          begin
            dir_r      <= lvl_r;
            mode_r     <= `MODE_SINGLE;
            state_r    <= S_OPEN;
            hold_pos_r <= 1'b0;
          end
          else if (!level_control && cmd[3] && cmd[1:0] != `MODE_LOCKED)
          begin
            dir_r      <= cmd[2];
            mode_r     <= cmd[1:0]; // [RULE5]
            state_r    <= S_OPEN;
            counting_r <= 1'b0;
            hold_pos_r <= 1'b0;
          end
        S_OPEN:
          if (level_control)
          begin
            if (!(dir_r ? lvl_r : lvl_l))
            begin
              state_r <= S_HOMING; // [RULE16] [RULE17]
              mode_r  <= `MODE_LOCKED;
            end
          end
          else if (cmd[3] && cmd[1:0] == `MODE_LOCKED)
          begin
            state_r <= S_HOMING; // [RULE4] [RULE7] [RULE10]
            mode_r  <= `MODE_LOCKED;
            buf_v_r <= 1'b0;
          end
          else if (cmd[3] && cmd[1:0] == `MODE_FREE
                   && mode_r == `MODE_SINGLE)
            begin
              mode_r     <= `MODE_FREE;
              hold_pos_r <= 1'b1; // Keep current position [RULE15]
            end
          else if (cmd[3] && cmd[2] == dir_r)
          begin
            mode_r     <= cmd[1:0]; // [RULE13]
            counting_r <= 1'b0;
            hold_pos_r <= 1'b0;
          end
          else if (cmd[3])
          begin
            buf_v_r <= 1'b1; // [RULE14]
            buf_r   <= cmd[2:0];
            state_r <= S_HOMING;
            mode_r  <= `MODE_LOCKED;
          end
          else if (mode_r == `MODE_SINGLE && wait_time_s != `WAIT_INFINITE)
          begin
            // [RULE7] Infinite wait never reaches this branch
            if (!counting_r && panel_past_83)
            begin
              counting_r <= 1'b1; // [RULE9]
              ms_r       <= 16'h0;
              sec_r      <= 8'h0;
            end
            else if (counting_r && ms_tick && ms_r >= 16'd999)
            begin
              ms_r  <= 16'h0;
              sec_r <= sec_r + 8'h1;
            end
            if (counting_r && sec_r >= wait_time_s)
            begin
              state_r <= S_HOMING; // [RULE6] [RULE8]
              mode_r  <= `MODE_LOCKED;
            end
          end
        default:
          state_r <= S_STARTUP;
      endcase
      // Overload watch last, so it outranks any state change in the case above
      if (panel_forced && state_r != S_OVERLOAD)
      begin
        if (ms_tick)
          force_ms_r <= force_ms_r + 16'h1;
        if (force_ms_r >= `FORCE_MS)
        begin
          state_r <= S_OVERLOAD; // [RULE22]
          ms_r    <= 16'h0;
        end
      end
      else if (!panel_forced)
        force_ms_r <= 16'h0;
    end
  end

  // Registered outputs; driven from the state, mode, direction, hold flag and ms counter
  wire blink = ms_r[9];
  wire [15:0] ovl_ph = ms_r;
  always @(posedge ref_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      lock_release     <= 1'b0;
      drive_enable     <= 1'b0;
      drive_open_left  <= 1'b0;
      drive_open_right <= 1'b0;
      drive_home       <= 1'b0;
      led_stop_red     <= 1'b1;
      led_left_green   <= 1'b1;
      led_right_green  <= 1'b1;
      buzzer_on        <= 1'b1;
      buzzer_two_tone  <= 1'b0;
      mode_out         <= `MODE_LOCKED;
      overload_out     <= 1'b0;
    end
    else
    begin
      mode_out     <= mode_r;
      overload_out <= (state_r == S_OVERLOAD);
      // Drive is off in fire mode so the panel turns freely [RULE20]
      lock_release <= (state_r == S_FIRE) || (state_r == S_OPEN);
      drive_enable <= (state_r == S_HOMING) || (state_r == S_OPEN) ||
                      (state_r == S_OVERLOAD);
      drive_open_left  <= (state_r == S_OPEN) && !dir_r && !hold_pos_r;
      drive_open_right <= (state_r == S_OPEN) && dir_r && !hold_pos_r;
      drive_home   <= (state_r == S_HOMING); // [RULE2] [RULE4] [RULE8]
      buzzer_two_tone <= (state_r == S_STARTUP) && (ms_r >= `TONE_MS/2);
      case (state_r)
        S_STARTUP:
        begin
          led_stop_red    <= 1'b1; // [RULE1]
          led_left_green  <= 1'b1;
          led_right_green <= 1'b1;
          buzzer_on       <= (ms_r < `TONE_MS);
        end
        S_OVERLOAD:
        begin
          led_stop_red    <= blink; // [RULE22]
          led_left_green  <= blink;
          led_right_green <= blink;
          buzzer_on       <= (ovl_ph < 6 * `BEEP_MS) &&
                             ((ovl_ph / `BEEP_MS) % 2 == 0);
        end
        S_FIRE:
        begin
          led_stop_red    <= 1'b0;
          led_left_green  <= 1'b1;
          led_right_green <= 1'b1;
          buzzer_on       <= 1'b0;
        end
        default:
        begin
          led_stop_red    <= (mode_r != `MODE_FREE);
          led_left_green  <= (mode_r != `MODE_LOCKED) && !dir_r;
          led_right_green <= (mode_r != `MODE_LOCKED) && dir_r;
          buzzer_on       <= 1'b0;
        end
      endcase
    end
  end
endmodule // swing_gate_mode_control
`default_nettype wire

// ==== testbench/gate_checker.sv ====
// Assertion checker for the swing gate mode controller
`timescale 1ns/1ps
`default_nettype none
`include "gate_defines.vh"
module gate_checker #(
  parameter integer CYC_PER_MS   = 10,
  parameter integer DEBOUNCE_CYC = 4
) (
  input wire logic       ref_clk,
  input wire logic       rstn,
  input wire logic       fire_alarm_loop_closed,
  input wire logic [7:0] wait_time_s,
  input wire logic       panel_past_83,
  input wire logic       lock_release,
  input wire logic       drive_enable,
  input wire logic       drive_open_left,
  input wire logic       drive_open_right,
  input wire logic       drive_home,
  input wire logic       led_stop_red,
  input wire logic       led_left_green,
  input wire logic       led_right_green,
  input wire logic       buzzer_on,
  input wire logic [1:0] mode_out,
  input wire logic       overload_out
);
  localparam integer STARTUP = `STARTUP_MS * CYC_PER_MS;
  logic [31:0] up_r;
  logic [31:0] open_r;
  // Uptime, and time spent open beyond 83 degrees in single passage
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
    begin
      up_r   <= 32'h0;
      open_r <= 32'h0;
    end
    else
    begin
      up_r   <= (up_r == 32'hffffffff) ? up_r : up_r + 32'h1;
      open_r <= (mode_out == `MODE_SINGLE && panel_past_83) ?
                open_r + 32'h1 : 32'h0;
    end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Fire loop held open well past the debounce time
  sequence fire_open_s;
    (up_r > STARTUP && !fire_alarm_loop_closed)[*8]
      ##1 (!fire_alarm_loop_closed)[*8];
  endsequence
  sequence lamps_on_s;
    (led_stop_red && led_left_green && led_right_green)[*8];
  endsequence
  a_fire_unlocks: assert property (
    fire_open_s |-> lock_release && !drive_enable)
    else $error("fire loop open but drive still powered");
  a_startup_lamps: assert property (
    $rose(rstn) |-> ##1 lamps_on_s)
    else $error("lamps not all lit after reset");
  a_startup_end: assert property (
    up_r == STARTUP + 40 |-> led_stop_red && !led_left_green &&
    !led_right_green && !buzzer_on && mode_out == `MODE_LOCKED)
    else $error("startup did not end in locked idle");
  a_single_unlock: assert property (
    mode_out == `MODE_SINGLE && (drive_open_left || drive_open_right)
    |-> lock_release)
    else $error("opening while locked");
  a_one_way: assert property (
    !(drive_open_left && drive_open_right))
    else $error("both directions driven");
  a_locked_shut: assert property (
    mode_out == `MODE_LOCKED |-> !drive_open_left && !drive_open_right)
    else $error("opening in locked mode");
  a_free_holds: assert property (
    mode_out == `MODE_FREE && fire_alarm_loop_closed && !overload_out
    |-> !drive_home && !led_stop_red)
    else $error("free mode homing or red lit");
  a_single_red: assert property (
    mode_out == `MODE_SINGLE && fire_alarm_loop_closed && !overload_out
    |-> led_stop_red)
    else $error("single passage without red lamp");
  a_wait_count: assert property (
    $past(mode_out) == `MODE_SINGLE && $rose(drive_home) &&
    wait_time_s != 8'hff
    |-> $past(open_r) >= wait_time_s * 32'd1000 * CYC_PER_MS - 20)
    else $error("passage closed before wait time");
  a_overload_lamps: assert property (
    overload_out |-> led_stop_red == led_left_green &&
    led_left_green == led_right_green)
    else $error("overload lamps not blinking together");
endmodule // gate_checker
bind swing_gate_mode_control gate_checker #(
  .CYC_PER_MS  (CYC_PER_MS),
  .DEBOUNCE_CYC(DEBOUNCE_CYC)
) i_gate_checker (
  .ref_clk, .rstn, .fire_alarm_loop_closed, .wait_time_s, .panel_past_83,
  .lock_release, .drive_enable, .drive_open_left, .drive_open_right,
  .drive_home, .led_stop_red, .led_left_green, .led_right_green,
  .buzzer_on, .mode_out, .overload_out
);
`default_nettype wire

// ==== testbench/panel_mech.sv ====
// Behavioural swing panel with home and 83 degree sensors
`timescale 1ns/1ps
`default_nettype none
module panel_mech (
  input  wire logic ref_clk,
  input  wire logic drive_enable,
  input  wire logic drive_open_left,
  input  wire logic drive_open_right,
  input  wire logic drive_home,
  output wire logic panel_at_home,
  output wire logic panel_past_83
);
  logic [6:0] angle_r = 7'h00;
  // One degree per cycle; opening needs power, homing follows drive_home
  always @(posedge ref_clk)
    if (drive_enable && (drive_open_left || drive_open_right) &&
        angle_r < 7'h5a)
      angle_r <= angle_r + 7'h01;
    else if (drive_home && angle_r != 7'h00)
      angle_r <= angle_r - 7'h01;
  assign panel_at_home = (angle_r == 7'h00);
  assign panel_past_83 = (angle_r > 7'h53);
endmodule // panel_mech
`default_nettype wire

// ==== testbench/tb.sv ====
// Testbench for the swing gate mode controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       ref_clk = 1'b0;
  logic       rstn = 1'b0;
  logic       panel_stop_btn, panel_left_btn, panel_right_btn;
  logic       access_control_stop, access_control_left, access_control_right;
  logic       fire_alarm_loop_closed, level_control, panel_forced;
  logic [7:0] wait_time_s;
  wire        lock_release, drive_enable, drive_open_left, drive_open_right;
  wire        drive_home, led_stop_red, led_left_green, led_right_green;
  wire        buzzer_on, buzzer_two_tone, overload_out;
  wire        panel_at_home, panel_past_83;
  wire  [1:0] mode_out;
  wire  [5:0] obs;
  wire  [4:0] ovl;
  integer     mismatches = 0;
  integer     checked = 0;
  integer     n;
  // Clock at 200 MHz
  initial forever #2.5 ref_clk = ~ref_clk;
  assign obs = {lock_release, panel_past_83, panel_at_home, drive_home,
                drive_open_right, drive_open_left};
  assign ovl = {overload_out, led_stop_red, led_left_green, led_right_green,
                buzzer_on};
  // Short millisecond so the overload wait fits the run
  swing_gate_mode_control #(
    .CYC_PER_MS  (4),
    .DEBOUNCE_CYC(4)
  ) i_swing_gate_mode_control (
    .ref_clk, .rstn, .panel_stop_btn, .panel_left_btn, .panel_right_btn,
    .access_control_stop, .access_control_left, .access_control_right,
    .fire_alarm_loop_closed,
    .level_control, .wait_time_s, .release_lock_engaged(1'b1),
    .panel_at_home, .panel_past_83, .panel_forced, .lock_release,
    .drive_enable, .drive_open_left, .drive_open_right, .drive_home,
    .led_stop_red, .led_left_green, .led_right_green, .buzzer_on,
    .buzzer_two_tone, .mode_out, .overload_out
  );
  panel_mech i_panel_mech (
    .ref_clk, .drive_enable, .drive_open_left, .drive_open_right,
    .drive_home, .panel_at_home, .panel_past_83
  );
  task automatic complete_run;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    checked = checked + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input integer k);
    repeat (k) @(negedge ref_clk);
  endtask
  // Bounded wait for one observed line to go high; n holds the cycles
  task automatic wait_on(input integer sel, input integer lim);
    n = 0;
    while (obs[sel] !== 1'b1 && n < lim)
    begin
      @(negedge ref_clk);
      n = n + 1;
    end
    if (obs[sel] !== 1'b1)
    begin
      mismatches = mismatches + 1;
      $display("wrong value wait %0d expected 1 seen 0", sel);
      complete_run;
    end
  endtask
  // Bits: panel stop, left, right, connector stop, left, right
  task automatic drive(input logic [5:0] v);
    {panel_stop_btn, panel_left_btn, panel_right_btn,
     access_control_stop, access_control_left, access_control_right} = v;
  endtask
  // Pulse long enough to pass the debouncer, then a gap of the same
  task automatic press(input logic [5:0] v);
    drive(v);
    cyc(12);
    drive(6'h00);
    cyc(12);
  endtask
  initial
  begin
    drive(6'h00);
    fire_alarm_loop_closed = 1'b1;
    panel_forced = 1'b0;
    level_control = 1'b0;
    wait_time_s = 8'h01;
    cyc(6);
    rstn = 1'b1;
    cyc(10);
    chk("lamps", 8'h07, {led_stop_red, led_left_green, led_right_green});
    chk("tone", 8'h02, {buzzer_on, buzzer_two_tone});
    cyc(12040);
    chk("idle", 8'h04, {led_stop_red, led_left_green, led_right_green});
    chk("mode", 8'h00, mode_out);
    press(6'h10);
    wait_on(0, 50);
    chk("unlock", 8'h01, lock_release);
    chk("mode", 8'h01, mode_out);
    wait_on(4, 200);
    wait_on(2, 12000);
    chk("wait", 8'h01, n > 3969 && n < 4060);
    wait_on(3, 200);
    cyc(4);
    chk("mode", 8'h00, mode_out);
    press(6'h01);
    wait_on(1, 50);
    chk("right lamp", 8'h01, led_right_green);
    wait_on(4, 200);
    press(6'h30);
    chk("mode", 8'h02, mode_out);
    chk("held", 8'h01, panel_past_83 && !drive_home);
    cyc(4500);
    chk("free", 8'h02, mode_out);
    press(6'h04);
    wait_on(2, 50);
    chk("mode", 8'h00, mode_out);
    wait_on(3, 200);
    wait_time_s = 8'hff;
    press(6'h02);
    wait_on(4, 200);
    cyc(4500);
    chk("open", 8'h01, mode_out);
    press(6'h01);
    wait_on(3, 200);
    wait_on(1, 50);
    chk("buffered", 8'h01, led_right_green);
    wait_on(4, 200);
    press(6'h20);
    press(6'h08);
    wait_on(1, 50);
    chk("no home", 8'h00, panel_at_home);
    press(6'h20);
    wait_on(2, 50);
    chk("mode", 8'h00, mode_out);
    wait_on(3, 200);
    level_control = 1'b1;
    drive(6'h02);
    wait_on(0, 50);
    drive(6'h06);
    cyc(20);
    chk("stop ignored", 8'h01, drive_open_left);
    drive(6'h00);
    wait_on(2, 50);
    chk("mode", 8'h00, mode_out);
    wait_on(3, 200);
    drive(6'h02);
    wait_on(0, 50);
    drive(6'h22);
    wait_on(2, 50);
    chk("mode", 8'h00, mode_out);
    drive(6'h00);
    wait_on(3, 200);
    drive(6'h08);
    wait_on(1, 50);
    drive(6'h00);
    wait_on(2, 50);
    wait_on(3, 200);
    level_control = 1'b0;
    press(6'h10);
    wait_on(4, 200);
    panel_forced = 1'b1;
    cyc(39900);
    chk("overload", 8'h00, overload_out);
    cyc(200);
    chk("ovl beep", 8'h11, ovl);
    cyc(2140);
    chk("ovl blink", 8'h1e, ovl);
    panel_forced = 1'b0;
    fire_alarm_loop_closed = 1'b0;
    cyc(20);
    press(6'h10);
    chk("fire", 8'h02, {lock_release, drive_enable});
    chk("ignored", 8'h00, drive_open_left);
    fire_alarm_loop_closed = 1'b1;
    cyc(20);
    chk("lamps", 8'h07, {led_stop_red, led_left_green, led_right_green});
    cyc(12040);
    chk("homing", 8'h01, drive_home);
    wait_on(3, 200);
    chk("mode", 8'h00, mode_out);
    complete_run;
  end
endmodule // tb
`default_nettype wire
